// file: dv/mpbi_host_model.sv
// host model: one bus cycle per call in the configured bus style
`timescale 1ns/10ps
module mpbi_host_model (
    // clock and configuration
    input wire logic clk,
    input wire mpbi_pkg::mpbi_cfg_t cfg,
    // host pins
    output mpbi_pkg::mpbi_ctrl_t ctrl,
    output logic [15:0] bus,
    output logic [7:0] port_a
);
    // enable-style hosts park the enable low, others park strobes high
    task automatic idle(input mpbi_pkg::mpbi_bus_t m);
        ctrl = (m == mpbi_pkg::MPBI_BUS_RW_ENABLE) ? 5'h14 : 5'h1c;
    endtask
    task automatic cycle(input logic rd, lat, f, input logic [16:0] a, input logic [7:0] wd);
        logic rw;
        logic nm;
        rw = cfg.bus_type == mpbi_pkg::MPBI_BUS_RW_ENABLE;
        nm = cfg.bus_type == mpbi_pkg::MPBI_BUS_NONMUX;
        bus = (cfg.bus_type == mpbi_pkg::MPBI_BUS_PAGE) ? {a[7:0], a[15:8]} : a[15:0];
        if (cfg.bus_type == mpbi_pkg::MPBI_BUS_SPLIT_LOW) bus[7:0] = a[11:4];
        port_a = {4'h0, a[3:1], cfg.use_a16 ? a[16] : a[0]};
        if (rw) ctrl.ctrl_in_write = rd;
        if (lat && !nm) begin
            ctrl.address_latch_strobe = 1'b1;
            repeat (5) @(negedge clk);
            ctrl.address_latch_strobe = 1'b0;
        end
        repeat (5) @(negedge clk);
        // released lines show a changed pattern, never the old value
        if (nm) port_a = rd ? ~wd : wd;
        else bus[7:0] = rd ? ~bus[7:0] : wd;
        if (rw) ctrl.ctrl_in_read = 1'b1;
        else if (!rd) ctrl.ctrl_in_write = 1'b0;
        else if (f) ctrl.ctrl_in_fetch = 1'b0;
        else ctrl.ctrl_in_read = 1'b0;
        repeat (6) @(negedge clk);
        // read/write held past the enable so the strobe end sees it
        ctrl[4:2] = {rw ? rd : 1'b1, !rw, 1'b1};
        repeat (5) @(negedge clk);
        idle(cfg.bus_type);
        bus[7:0] = ~bus[7:0];
    endtask
    initial begin
        bus = 16'h0000;
        port_a = 8'h00;
        idle(mpbi_pkg::MPBI_BUS_CLASSIC);
    end
endmodule // mpbi_host_model

// file: dv/mpbi_props.sv
// checker: port-level properties of the host parallel bus interface
`timescale 1ns/10ps
module mpbi_props (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched ports
    input wire mpbi_pkg::mpbi_cfg_t cfg,
    input wire mpbi_pkg::mpbi_ctrl_t ctrl,
    input wire logic shared_addr_data_port_oe,
    input wire logic port_a_oe,
    input wire logic resource_sel,
    input wire mpbi_pkg::mpbi_req_t req,
    input wire logic write_pulse,
    input wire logic logic_array_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic classic = cfg.bus_type == mpbi_pkg::MPBI_BUS_CLASSIC;
    wire logic page = cfg.bus_type == mpbi_pkg::MPBI_BUS_PAGE;
    sequence read_idle;
        (ctrl.ctrl_in_read && ctrl.ctrl_in_fetch)[*5];
    endsequence
    sequence write_end;
        classic && resource_sel && $rose(ctrl.ctrl_in_write);
    endsequence
    sel_gates_drive_a: assert property ($rose(shared_addr_data_port_oe) |-> $past(resource_sel))
        else $error("data port driven without select");
    read_release_a: assert property (classic throughout read_idle |=> !shared_addr_data_port_oe)
        else $error("data port still driven after read");
    pulse_after_write_a: assert property (write_end |-> ##[2:8] write_pulse)
        else $error("no write pulse after write strobe");
    pulse_single_a: assert property (write_pulse |=> !write_pulse)
        else $error("write pulse longer than one cycle");
    port_a_data_a: assert property (port_a_oe |-> !shared_addr_data_port_oe &&
        (cfg.bus_type == mpbi_pkg::MPBI_BUS_NONMUX || !cfg.addr_out_on_b))
        else $error("port A driven outside separate bus");
    latch_hold_a: assert property ((!ctrl.address_latch_strobe && (classic || page))[*5] |-> $stable(req.addr[15:8]))
        else $error("latched address moved without strobe");
    byte_lane_a: assert property (req.rd || req.wr |-> req.odd_byte == req.addr[0])
        else $error("byte lane does not follow address bit 0");
    spare_input_a: assert property ((cfg.bus_type == mpbi_pkg::MPBI_BUS_ONE_READ && ctrl.ctrl_in_fetch)[*5] |-> logic_array_in)
        else $error("unused control input not passed on");
endmodule // mpbi_props
bind mpbi_core mpbi_props mpbi_props_inst (.clk, .nrst, .cfg, .ctrl, .shared_addr_data_port_oe,
    .port_a_oe, .resource_sel, .req, .write_pulse, .logic_array_in);

// file: dv/tb.sv
// testbench: host cycles in every bus style, checked against a queue of expectations
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    mpbi_pkg::mpbi_cfg_t cfg = '0;
    mpbi_pkg::mpbi_ctrl_t ctrl;
    mpbi_pkg::mpbi_req_t req;
    logic [15:0] bus, sh_wire;
    logic [7:0] pa_host, pa_wire, sh_o, pa_o, wdata, pb, rdata = 8'h00;
    logic sh_oe, pa_oe, wp, lai, oe_q = 1'b0, sel = 1'b1;
    logic [31:0] lfsr = 32'hd4d9_720f;
    logic [16:0] amask = 17'h1_ffff;
    logic [24:0] expq[$];
    int fail_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    assign sh_wire = sh_oe ? {bus[15:8], sh_o} : bus;
    assign pa_wire = pa_oe ? pa_o : pa_host;
    mpbi_host_model mpbi_host_model_inst (.clk(clk), .cfg(cfg), .ctrl(ctrl), .bus(bus),
        .port_a(pa_host));
    mpbi_core mpbi_core_inst (.clk(clk), .nrst(nrst), .cfg(cfg), .ctrl(ctrl),
        .shared_addr_data_port_i(sh_wire), .shared_addr_data_port_o(sh_o),
        .shared_addr_data_port_oe(sh_oe), .port_a_i(pa_wire), .port_a_o(pa_o),
        .port_a_oe(pa_oe), .port_b_o(pb), .resource_sel(sel), .read_data(rdata), .req(req),
        .write_data(wdata), .write_pulse(wp), .logic_array_in(lai));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic op(input logic rd, lat, f, input logic [16:0] a);
        lfsr = nxt(lfsr);
        rdata = lfsr[31:24];
        if (sel) expq.push_back({a & amask, rdata});
        mpbi_host_model_inst.cycle(rd, lat, f, a, rdata);
    endtask
    // a result is a write pulse or the first cycle of a data drive
    always @(negedge clk) begin : mon
        logic [24:0] e;
        if (wp || ((sh_oe || pa_oe) && !oe_q)) begin
            if (expq.size() == 0) chk(25'h0_0000_00, 25'h1_ffff_ff);
            else begin
                e = expq.pop_front();
                chk({req.addr & amask, wp ? wdata : pa_oe ? pa_o : sh_o}, e);
                if (wp) chk({17'h0_0000, pb}, {17'h0_0000, e[15:8]});
            end
        end
        oe_q <= sh_oe || pa_oe;
    end
    initial begin
        logic [16:0] a;
        // address out goes to port B so port A stays free for inputs
        cfg.addr_out_on_b = 1'b1;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        for (int m = 0; m < 6; m++) begin
            // deselect while the synchronised pins catch up with the new bus style
            sel = 1'b0;
            cfg.bus_type = mpbi_pkg::mpbi_bus_t'(m);
            cfg.use_a16 = m == 0;
            mpbi_host_model_inst.idle(cfg.bus_type);
            amask = (m == 3) ? 17'h0_0fff : 17'h1_ffff;
            repeat (6) @(negedge clk);
            sel = 1'b1;
            lfsr = nxt(lfsr);
            a = {m == 0 && lfsr[16], lfsr[15:0]};
            op(1'b0, 1'b1, 1'b0, a);
            op(1'b1, 1'b1, m == 0, a ^ 17'h0_0001);
            // page hits and bursts step only the low address, no new strobe
            for (int k = 1; k < (m == 3 ? 16 : m == 2 ? 4 : 1); k++)
                op(1'b1, 1'b0, m == 3, m == 2 ? {a[16:8], a[7:0] + 8'(k)} : {a[16:4], 4'(k)});
            if (m == 1) chk({24'h00_0000, lai}, 25'h0_0000_01);
        end
        // nothing may answer while no resource is selected
        sel = 1'b0;
        op(1'b0, 1'b1, 1'b0, a);
        op(1'b1, 1'b1, 1'b0, a);
        sel = 1'b1;
        for (int i = 0; i < 50 && expq.size() > 0; i++) @(negedge clk);
        if (expq.size() != 0) fail_count++;
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule // tb

// file: hdl/mpbi_core.sv
// host parallel bus interface: strobe decode, address latch, data port drive
`timescale 1ns/10ps
module mpbi_core (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // stored configuration
    input wire mpbi_pkg::mpbi_cfg_t cfg,
    // host control pins
    input wire mpbi_pkg::mpbi_ctrl_t ctrl,
    // shared address/data port
    input wire logic [15:0] shared_addr_data_port_i,
    output logic [7:0] shared_addr_data_port_o,
    output logic shared_addr_data_port_oe,
    // port A pins
    input wire logic [7:0] port_a_i,
    output logic [7:0] port_a_o,
    output logic port_a_oe,
    // port B address out
    output logic [7:0] port_b_o,
    // internal resource side
    input wire logic resource_sel,
    input wire logic [7:0] read_data,
    output mpbi_pkg::mpbi_req_t req,
    output logic [7:0] write_data,
    output logic write_pulse,
    output logic logic_array_in
);
    localparam int NS = mpbi_pkg::MPBI_SYNC_STAGES;
    localparam int NC = 5;

    // three-stage synchronisers on host pins
    logic [NC-1:0] ctrl_raw;
    logic [NC-1:0] s1_reg, s2_reg, s3_reg;
    logic [NC-1:0] ctrl_s_reg, ctrl_s_next;
    logic [15:0] ad_s1_reg, ad_s2_reg, ad_s3_reg;
    logic [7:0] pa_s1_reg, pa_s2_reg, pa_s3_reg;

    assign ctrl_raw = ctrl;

    always_comb begin
        ctrl_s_next = ctrl_s_reg;
        for (int i = 0; i < NC; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                ctrl_s_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // strobe-style idle pin levels, so leaving reset shows no false strobe edge except on the read/write-plus-enable bus
            s1_reg <= mpbi_pkg::MPBI_CTRL_IDLE;
            s2_reg <= mpbi_pkg::MPBI_CTRL_IDLE;
            s3_reg <= mpbi_pkg::MPBI_CTRL_IDLE;
            ctrl_s_reg <= mpbi_pkg::MPBI_CTRL_IDLE;
            ad_s1_reg <= 16'h0000;
            ad_s2_reg <= 16'h0000;
            ad_s3_reg <= 16'h0000;
            pa_s1_reg <= mpbi_pkg::MPBI_BYTE_RESET;
            pa_s2_reg <= mpbi_pkg::MPBI_BYTE_RESET;
            pa_s3_reg <= mpbi_pkg::MPBI_BYTE_RESET;
        end else begin
            s1_reg <= ctrl_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            ctrl_s_reg <= ctrl_s_next;
            ad_s1_reg <= shared_addr_data_port_i;
            ad_s2_reg <= ad_s1_reg;
            ad_s3_reg <= ad_s2_reg;
            pa_s1_reg <= port_a_i;
            pa_s2_reg <= pa_s1_reg;
            pa_s3_reg <= pa_s2_reg;
        end
    end

    // clean host signals (bit order matches the ctrl struct)
    logic c_wr, c_rd, c_fetch, c_als;
    assign c_wr = ctrl_s_reg[4];
    assign c_rd = ctrl_s_reg[3];
    assign c_fetch = ctrl_s_reg[2];
    assign c_als = ctrl_s_reg[1];

    // strobe decode by configured bus type; strobes are active low on the pins, except the active-high enable of the read/write-plus-enable bus
    logic rd_act, wr_act, mux_bus, uses_fetch_pin;
    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        mux_bus = 1'b1;
        uses_fetch_pin = 1'b0;
        case (cfg.bus_type) // see RULE1
            mpbi_pkg::MPBI_BUS_CLASSIC, mpbi_pkg::MPBI_BUS_PAGE,
            mpbi_pkg::MPBI_BUS_SPLIT_LOW: begin
                rd_act = !c_rd || !c_fetch; // see RULE10
                wr_act = !c_wr;
                uses_fetch_pin = 1'b1;
            end
            mpbi_pkg::MPBI_BUS_ONE_READ: begin
                rd_act = !c_rd; // see RULE14
                wr_act = !c_wr;
            end
            mpbi_pkg::MPBI_BUS_RW_ENABLE: begin
                rd_act = c_rd && c_wr; // see RULE19
                wr_act = c_rd && !c_wr; // see RULE20
            end
            mpbi_pkg::MPBI_BUS_NONMUX: begin
                rd_act = !c_rd;
                wr_act = !c_wr;
                mux_bus = 1'b0;
            end
            default: begin
                rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
    end

    // spare third control input goes to the logic array
    assign logic_array_in = uses_fetch_pin ? 1'b0 : c_fetch; // see RULE9

    // address latch: upper part held across page hits and bursts
    logic [16:0] lat_reg, lat_next;
    logic [7:0] wd_reg, wd_next;
    logic wr_d_reg, wr_d_next;
    logic wp_reg, wp_next;

    always_comb begin
        lat_next = lat_reg;
        if (mux_bus && c_als) begin // see RULE2 // see RULE11
            case (cfg.bus_type)
                mpbi_pkg::MPBI_BUS_PAGE: begin
                    lat_next[15:8] = ad_s3_reg[7:0]; // see RULE12
                end
                mpbi_pkg::MPBI_BUS_SPLIT_LOW: begin
                    lat_next[11:4] = ad_s3_reg[7:0]; // see RULE16 // see RULE17
                end
                default: begin
                    lat_next[15:0] = ad_s3_reg;
                end
            endcase
        end
        lat_next[16] = cfg.use_a16 ? pa_s3_reg[0] : 1'b0; // see RULE15 // see RULE5
    end

    // effective address: latch, with live low bits in page and split-low modes, live shared port on a non-multiplexed bus
    logic [16:0] addr_eff;
    always_comb begin
        addr_eff = lat_reg;
        case (cfg.bus_type)
            mpbi_pkg::MPBI_BUS_NONMUX: begin
                addr_eff[15:0] = ad_s3_reg; // see RULE8 // see RULE6
            end
            mpbi_pkg::MPBI_BUS_PAGE: begin
                addr_eff[7:0] = ad_s3_reg[15:8]; // see RULE13
            end
            mpbi_pkg::MPBI_BUS_SPLIT_LOW: begin
                addr_eff[3:0] = pa_s3_reg[3:0]; // see RULE18
            end
            default: begin
                addr_eff = lat_reg;
            end
        endcase
        if (cfg.use_a16 && !mux_bus) begin
            addr_eff[16] = pa_s3_reg[0];
        end
    end

    // write data: taken while strobe active, pulse at its trailing edge
    logic [7:0] data_in;
    assign data_in = mux_bus ? ad_s3_reg[7:0] : pa_s3_reg;

    always_comb begin
        wd_next = wr_act ? data_in : wd_reg;
        wr_d_next = wr_act;
        wp_next = wr_d_reg && !wr_act && resource_sel; // see RULE20
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lat_reg <= mpbi_pkg::MPBI_ADDR_RESET;
            wd_reg <= mpbi_pkg::MPBI_BYTE_RESET;
            wr_d_reg <= 1'b0;
            wp_reg <= 1'b0;
        end else begin
            lat_reg <= lat_next;
            wd_reg <= wd_next;
            wr_d_reg <= wr_d_next;
            wp_reg <= wp_next;
        end
    end

    // request to internal resources; high byte enable is ignored on 8-bit data
    always_comb begin
        req.addr = addr_eff;
        req.rd = rd_act;
        req.wr = wr_act;
        req.odd_byte = addr_eff[0]; // see RULE7
    end

    assign write_data = wd_reg;
    assign write_pulse = wp_reg;

    // data drive: only a selected read drives the bus
    logic [7:0] rdq_reg, rdq_next;
    logic drv_reg, drv_next;
    always_comb begin
        drv_next = resource_sel && rd_act; // see RULE3
        rdq_next = drv_next ? read_data : rdq_reg;
    end

    // latched address out on A or B
    logic [7:0] aout_reg, aout_next;
    always_comb begin
        aout_next = cfg.addr_out_high ? addr_eff[15:8] : addr_eff[7:0]; // see RULE4
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdq_reg <= mpbi_pkg::MPBI_BYTE_RESET;
            drv_reg <= 1'b0;
            aout_reg <= mpbi_pkg::MPBI_BYTE_RESET;
        end else begin
            rdq_reg <= rdq_next;
            drv_reg <= drv_next;
            aout_reg <= aout_next;
        end
    end

    // port A carries data on a non-multiplexed bus, else optional address out
    assign shared_addr_data_port_o = rdq_reg;
    assign shared_addr_data_port_oe = drv_reg && mux_bus; // see RULE3
    assign port_a_o = mux_bus ? aout_reg : rdq_reg;
    assign port_a_oe = mux_bus ? (!cfg.addr_out_on_b && !cfg.use_a16) : drv_reg; // see RULE6
    assign port_b_o = aout_reg; // see RULE4
endmodule // mpbi_core

// file: hdl/mpbi_pkg.sv
// package: constants, bus type codes and carrier structs of the host parallel bus interface
// Functional notes
// RULE1: bus type comes from a stored configuration input, not from run-time signals.
// RULE2: multiplexed bus latches shared-port address while address strobe is high.
// RULE3: shared port driven only when a resource is selected and read is active.
// RULE4: latched address bits can be presented on port A or port B.
// RULE5: address bits above sixteen come from general port pins into decoding.
// RULE6: non-multiplexed bus takes address on shared port, data on port A.
// RULE7: with 8-bit data, address bit zero picks even/odd byte; high enable ignored.
// RULE8: address strobe is optional on a non-multiplexed bus; decode directly.
// RULE9: unused third control input is passed to the logic array.
// RULE10: classic multiplexed host uses separate fetch, read and write strobes.
// RULE11: non-page mode latches the address on every strobe.
// RULE12: page mode muxes data with upper address byte; low byte on dedicated lines.
// RULE13: page hit without strobe keeps upper latch and uses new low byte.
// RULE14: single-read-strobe configuration uses the second input as sole read strobe.
// RULE15: port A bit 0 may supply address bit 16.
// RULE16: split-low host takes address bits 3..0 on port A, shared bit 0 is A4.
// RULE17: split-low host in 8-bit mode latches address bits 11..4 from shared port.
// RULE18: burst fetches hold the upper latch while host steps the low four bits.
// RULE19: read/write-plus-enable hosts run 8-bit multiplexed, rw on first input.
// RULE20: rw high during strobe is read, low is write; data sampled at strobe end.
package mpbi_pkg;
    // bus type codes held in configuration
    typedef enum logic [2:0] {
        MPBI_BUS_CLASSIC,
        MPBI_BUS_ONE_READ,
        MPBI_BUS_PAGE,
        MPBI_BUS_SPLIT_LOW,
        MPBI_BUS_RW_ENABLE,
        MPBI_BUS_NONMUX
    } mpbi_bus_t;

    localparam int MPBI_ADDR_W = 17;
    localparam int MPBI_SYNC_STAGES = 3;
    localparam logic [16:0] MPBI_ADDR_RESET = 17'h0_0000;
    localparam logic [7:0] MPBI_BYTE_RESET = 8'h00;
    // pin levels of an idle host: write, read and fetch strobes high, latch strobe low
    localparam logic [4:0] MPBI_CTRL_IDLE = 5'h1c;

    typedef struct packed {
        mpbi_bus_t bus_type;
        logic use_a16;
        logic addr_out_on_b;
        logic addr_out_high;
    } mpbi_cfg_t;

    typedef struct packed {
        logic ctrl_in_write;
        logic ctrl_in_read;
        logic ctrl_in_fetch;
        logic address_latch_strobe;
        logic high_byte_enable;
    } mpbi_ctrl_t;

    typedef struct packed {
        logic [16:0] addr;
        logic rd;
        logic wr;
        logic odd_byte;
    } mpbi_req_t;
endpackage
